// >>> src/tcdmx_consts.vh
/*
 * Constants of the two-channel downmixer: register map, control fields,
 * coding layouts, quantized gains and arithmetic widths.
 * Assumes inclusion by bare name from the design file; definitions only.
 */
`ifndef TCDMX_CONSTS_VH
`define TCDMX_CONSTS_VH

// ****************************************************************
// register map (byte addresses, one aligned 32-bit word each)
// ****************************************************************
`define TCDMX_ADDR_W         4
`define TCDMX_ADDR_CTRL      4'h0
`define TCDMX_ADDR_STATUS    4'h4
`define TCDMX_ADDR_COUNT     4'h8
`define TCDMX_DATA_W         32
`define TCDMX_RESP_OKAY      2'h0
`define TCDMX_RESP_SLVERR    2'h2

// ****************************************************************
// control register fields
// ****************************************************************
`define TCDMX_CTRL_MATRIX    0
`define TCDMX_CTRL_MONO      1
`define TCDMX_CTRL_LVL_OVR   2
`define TCDMX_CTRL_CMIX_LO   4
`define TCDMX_CTRL_SMIX_LO   6
`define TCDMX_CTRL_W         8
`define TCDMX_CTRL_RESET     8'h00

// status register fields
`define TCDMX_STAT_LAYOUT_LO 0
`define TCDMX_STAT_CMIX_LO   4
`define TCDMX_STAT_SMIX_LO   6
`define TCDMX_STAT_MONO      8
`define TCDMX_STAT_MATRIX    9
`define TCDMX_STAT_BUSY      10

// ****************************************************************
// coded channel layouts (front/rear)
// ****************************************************************
`define TCDMX_LAYOUT_W       3
`define TCDMX_LAYOUT_20      3'h2
`define TCDMX_LAYOUT_30      3'h3
`define TCDMX_LAYOUT_21      3'h4
`define TCDMX_LAYOUT_31      3'h5
`define TCDMX_LAYOUT_22      3'h6
`define TCDMX_LAYOUT_32      3'h7
`define TCDMX_LAYOUT_RESET   3'h2

// mix-level field codes
`define TCDMX_LVL_W          2
`define TCDMX_LVL_00         2'h0
`define TCDMX_LVL_01         2'h1
`define TCDMX_LVL_10         2'h2
`define TCDMX_LVL_11         2'h3

// ****************************************************************
// 6-bit quantized gains, fractions of 64
// ****************************************************************
`define TCDMX_K_W            6
`define TCDMX_K_FRAC         6
`define TCDMX_K_CONV_1000    6'h1a
`define TCDMX_K_CONV_0707    6'h12
`define TCDMX_K_CONV_0596    6'h0f
`define TCDMX_K_CONV_0500    6'h0d
`define TCDMX_K_CONV_0354    6'h09
`define TCDMX_K_ZERO         6'h00
`define TCDMX_K_MTX_1000     6'h14
`define TCDMX_K_MTX_0707     6'h0e

// ****************************************************************
// datapath widths
// ****************************************************************
`define TCDMX_SMP_W          16
`define TCDMX_ACC_W          26
`define TCDMX_CNT_W          32
`define TCDMX_CNT_ONE        32'h00000001

`endif

// >>> src/tcdmx_downmixer.v
/*
 * Two-channel downmixer: turns one sample frame of left, centre, right and
 * surround PCM into a conventional stereo pair, a matrix-surround pair, or
 * a mono sum, with 6-bit worst-case scaled gains. AXI4-Lite registers.
 * Assumes: one clock, synchronous active-low reset, upstream decoder gives
 * layout and header mix-level fields with every frame, samples are signed
 * 16-bit, a single surround arrives on the left-surround input.
 */
// Our own choices: the placing of the registers and register access over AXI4-Lite.
`timescale 1ns/10ps
`default_nettype none
`include "tcdmx_consts.vh"

// Functional notes
// - offers matrix-surround pair and conventional stereo pair, selectable
// - mono output is half the sum of the two conventional stereo channels
// - every applied gain within 0.5 dB of its nominal value
// - 3/2 conventional: front 1.0, centre clev, own surround slev
// - mono from conventional carries centre 2.0 clev, surround slev
// - single surround conventional: 0.7 slev per side, 1.4 slev in mono
// - clev and slev decoded from header mix-level fields, or from control fields when the level override is set
// - reserved level code 11 behaves as code 01
// - conventional drops centre or surround terms when not coded
// - 3/2 matrix: centre 0.707 both, surrounds minus left, plus right
// - single surround matrix: minus 0.707 left, plus 0.707 right
// - matrix drops centre term when no centre is coded
// - gains scaled so full-scale inputs never overflow
// - conventional gains scaled by 0.4143 for every layout
// - matrix gains scaled by 0.3204 for every layout
// - conventional gains 26, 18, 15, 13, 9 sixty-fourths
// - matrix gains 20 and 14 sixty-fourths
// - mono adds a further factor of one half
// - mono always derived from the conventional pair
// - gains summed into one output total at most one
module tcdmx_downmixer (
	input  wire                      clock_i,
	input  wire                      resetn_i,
	// sample stream from the decoder
	input  wire                      in_valid_i,
	output wire                      in_ready_o,
	input  wire [`TCDMX_LAYOUT_W-1:0] in_layout_i,
	input  wire [`TCDMX_LVL_W-1:0]   in_cmix_i,
	input  wire [`TCDMX_LVL_W-1:0]   in_smix_i,
	input  wire [`TCDMX_SMP_W-1:0]   in_left_i,
	input  wire [`TCDMX_SMP_W-1:0]   in_centre_i,
	input  wire [`TCDMX_SMP_W-1:0]   in_right_i,
	input  wire [`TCDMX_SMP_W-1:0]   in_lsur_i,
	input  wire [`TCDMX_SMP_W-1:0]   in_rsur_i,
	// two-channel stream to the output stage
	output wire                      out_valid_o,
	input  wire                      out_ready_i,
	output wire [`TCDMX_SMP_W-1:0]   out_left_o,
	output wire [`TCDMX_SMP_W-1:0]   out_right_o,
	output wire                      out_mono_o,
	// AXI4-Lite slave
	input  wire [`TCDMX_ADDR_W-1:0]  s_axi_awaddr,
	input  wire                      s_axi_awvalid,
	output wire                      s_axi_awready,
	input  wire [`TCDMX_DATA_W-1:0]  s_axi_wdata,
	input  wire [3:0]                s_axi_wstrb,
	input  wire                      s_axi_wvalid,
	output wire                      s_axi_wready,
	output wire [1:0]                s_axi_bresp,
	output wire                      s_axi_bvalid,
	input  wire                      s_axi_bready,
	input  wire [`TCDMX_ADDR_W-1:0]  s_axi_araddr,
	input  wire                      s_axi_arvalid,
	output wire                      s_axi_arready,
	output wire [`TCDMX_DATA_W-1:0]  s_axi_rdata,
	output wire [1:0]                s_axi_rresp,
	output wire                      s_axi_rvalid,
	input  wire                      s_axi_rready
);

	// ****************************************************************
	// gain lookup
	// ****************************************************************

	// centre level, reserved code falls back to the intermediate level
	function [`TCDMX_K_W-1:0] tcdmx_clev_k;
		input [`TCDMX_LVL_W-1:0] code;
		begin
			case (code)
				`TCDMX_LVL_00: tcdmx_clev_k = `TCDMX_K_CONV_0707;
				`TCDMX_LVL_01: tcdmx_clev_k = `TCDMX_K_CONV_0596;
				`TCDMX_LVL_10: tcdmx_clev_k = `TCDMX_K_CONV_0500;
				default:       tcdmx_clev_k = `TCDMX_K_CONV_0596;
			endcase
		end
	endfunction

	// surround level; single flags the 0.7 factor of a lone surround
	function [`TCDMX_K_W-1:0] tcdmx_slev_k;
		input [`TCDMX_LVL_W-1:0] code;
		input                    single;
		begin
			case (code)
				`TCDMX_LVL_00: tcdmx_slev_k = single ? `TCDMX_K_CONV_0500 : `TCDMX_K_CONV_0707;
				`TCDMX_LVL_10: tcdmx_slev_k = `TCDMX_K_ZERO;
				default:       tcdmx_slev_k = single ? `TCDMX_K_CONV_0354 : `TCDMX_K_CONV_0500;
			endcase
		end
	endfunction

	// signed sample times unsigned gain, widened to the accumulator
	function signed [`TCDMX_ACC_W-1:0] tcdmx_mul;
		input [`TCDMX_SMP_W-1:0] smp;
		input [`TCDMX_K_W-1:0]   k;
		begin
			tcdmx_mul = $signed(smp) * $signed({1'b0, k});
		end
	endfunction

	// ****************************************************************
	// registers
	// ****************************************************************
	reg  [`TCDMX_CTRL_W-1:0]   ctrl_q;
	reg  [`TCDMX_LAYOUT_W-1:0] last_layout_q;
	reg  [`TCDMX_LVL_W-1:0]    last_cmix_q;
	reg  [`TCDMX_LVL_W-1:0]    last_smix_q;
	reg  [`TCDMX_CNT_W-1:0]    frame_cnt_q;
	reg                        out_valid_q;
	reg  [`TCDMX_SMP_W-1:0]    out_left_q;
	reg  [`TCDMX_SMP_W-1:0]    out_right_q;
	reg                        out_mono_q;

	reg                        aw_held_q;
	reg  [`TCDMX_ADDR_W-1:0]   aw_addr_q;
	reg                        w_held_q;
	reg  [`TCDMX_DATA_W-1:0]   w_data_q;
	reg  [3:0]                 w_strb_q;
	reg                        bvalid_q;
	reg  [1:0]                 bresp_q;
	reg                        rvalid_q;
	reg  [`TCDMX_DATA_W-1:0]   rdata_q;
	reg  [1:0]                 rresp_q;

	// ****************************************************************
	// layout and level decode
	// ****************************************************************
	wire [`TCDMX_LVL_W-1:0] cmix_code;
	wire [`TCDMX_LVL_W-1:0] smix_code;
	wire                    has_centre;
	wire                    has_two_sur;
	wire                    has_one_sur;
	wire                    matrix_sel;
	wire                    mono_sel;

	// software may pin the levels, otherwise header fields rule
	assign cmix_code = ctrl_q[`TCDMX_CTRL_LVL_OVR] ?
		ctrl_q[`TCDMX_CTRL_CMIX_LO +: `TCDMX_LVL_W] : in_cmix_i;
	assign smix_code = ctrl_q[`TCDMX_CTRL_LVL_OVR] ?
		ctrl_q[`TCDMX_CTRL_SMIX_LO +: `TCDMX_LVL_W] : in_smix_i;

	// layouts below 2/0 carry no stereo pair; they are mixed as 2/0
	assign has_centre  = (in_layout_i == `TCDMX_LAYOUT_30) ||
	                     (in_layout_i == `TCDMX_LAYOUT_31) ||
	                     (in_layout_i == `TCDMX_LAYOUT_32);
	assign has_two_sur = (in_layout_i == `TCDMX_LAYOUT_22) ||
	                     (in_layout_i == `TCDMX_LAYOUT_32);
	assign has_one_sur = (in_layout_i == `TCDMX_LAYOUT_21) ||
	                     (in_layout_i == `TCDMX_LAYOUT_31);

	assign matrix_sel = ctrl_q[`TCDMX_CTRL_MATRIX];
	assign mono_sel   = ctrl_q[`TCDMX_CTRL_MONO];

	// ****************************************************************
	// conventional pair
	// ****************************************************************
	wire [`TCDMX_K_W-1:0]      k_conv_c;
	wire [`TCDMX_K_W-1:0]      k_conv_s;
	wire signed [`TCDMX_ACC_W-1:0] conv_l_acc;
	wire signed [`TCDMX_ACC_W-1:0] conv_r_acc;
	wire signed [`TCDMX_ACC_W-1:0] conv_sum;

	// gains are already the worst-case scaled ones, 0.4143 for all layouts
	assign k_conv_c = has_centre ? tcdmx_clev_k(cmix_code) : `TCDMX_K_ZERO;
	assign k_conv_s = (has_one_sur || has_two_sur) ?
		tcdmx_slev_k(smix_code, has_one_sur) : `TCDMX_K_ZERO;

	// a lone surround enters both sides; 26+18+18 stays below 64
	assign conv_l_acc = tcdmx_mul(in_left_i, `TCDMX_K_CONV_1000) +
	                    tcdmx_mul(in_centre_i, k_conv_c) +
	                    tcdmx_mul(in_lsur_i, k_conv_s);
	assign conv_r_acc = tcdmx_mul(in_right_i, `TCDMX_K_CONV_1000) +
	                    tcdmx_mul(in_centre_i, k_conv_c) +
	                    tcdmx_mul(has_one_sur ? in_lsur_i : in_rsur_i, k_conv_s);

	// mono sums the conventional pair and halves it
	assign conv_sum = conv_l_acc + conv_r_acc;

	// ****************************************************************
	// matrix-surround pair
	// ****************************************************************
	wire [`TCDMX_K_W-1:0]          k_mtx_c;
	wire signed [`TCDMX_ACC_W-1:0] mtx_sur;
	wire signed [`TCDMX_ACC_W-1:0] mtx_l_acc;
	wire signed [`TCDMX_ACC_W-1:0] mtx_r_acc;

	assign k_mtx_c = has_centre ? `TCDMX_K_MTX_0707 : `TCDMX_K_ZERO;

	// surround content, negated on the left and added on the right
	assign mtx_sur = has_two_sur ?
		tcdmx_mul(in_lsur_i, `TCDMX_K_MTX_0707) + tcdmx_mul(in_rsur_i, `TCDMX_K_MTX_0707) :
		(has_one_sur ? tcdmx_mul(in_lsur_i, `TCDMX_K_MTX_0707) :
		{`TCDMX_ACC_W{1'b0}});

	// 20+14+14+14 = 62, full scale cannot wrap
	assign mtx_l_acc = tcdmx_mul(in_left_i, `TCDMX_K_MTX_1000) +
	                   tcdmx_mul(in_centre_i, k_mtx_c) - mtx_sur;
	assign mtx_r_acc = tcdmx_mul(in_right_i, `TCDMX_K_MTX_1000) +
	                   tcdmx_mul(in_centre_i, k_mtx_c) + mtx_sur;

	// ****************************************************************
	// output selection
	// ****************************************************************
	wire signed [`TCDMX_ACC_W-1:0] sel_l_acc;
	wire signed [`TCDMX_ACC_W-1:0] sel_r_acc;
	wire signed [`TCDMX_ACC_W-1:0] mono_shift;
	wire [`TCDMX_SMP_W-1:0]        left_d;
	wire [`TCDMX_SMP_W-1:0]        right_d;
	wire [`TCDMX_SMP_W-1:0]        mono_d;

	assign sel_l_acc = matrix_sel ? mtx_l_acc : conv_l_acc;
	assign sel_r_acc = matrix_sel ? mtx_r_acc : conv_r_acc;

	// one extra bit of shift is the mono factor of one half
	assign mono_shift = conv_sum >>> (`TCDMX_K_FRAC + 1);
	assign mono_d     = mono_shift[`TCDMX_SMP_W-1:0];

	// truncation toward minus infinity costs under one lsb
	assign left_d  = mono_sel ? mono_d : sel_l_acc[`TCDMX_K_FRAC +: `TCDMX_SMP_W];
	assign right_d = mono_sel ? mono_d : sel_r_acc[`TCDMX_K_FRAC +: `TCDMX_SMP_W];

	// ****************************************************************
	// sample stream handshake
	// ****************************************************************
	wire in_fire;

	// one output stage; a stalled output holds the decoder off
	assign in_ready_o = !out_valid_q || out_ready_i;
	assign in_fire    = in_valid_i && in_ready_o;

	always @(posedge clock_i) begin
		if (!resetn_i) begin
			out_valid_q   <= 1'b0;
			out_left_q    <= {`TCDMX_SMP_W{1'b0}};
			out_right_q   <= {`TCDMX_SMP_W{1'b0}};
			out_mono_q    <= 1'b0;
			last_layout_q <= `TCDMX_LAYOUT_RESET;
			last_cmix_q   <= `TCDMX_LVL_00;
			last_smix_q   <= `TCDMX_LVL_00;
			frame_cnt_q   <= {`TCDMX_CNT_W{1'b0}};
		end else begin
			if (in_fire) begin
				out_valid_q   <= 1'b1;
				out_left_q    <= left_d;
				out_right_q   <= right_d;
				out_mono_q    <= mono_sel;
				last_layout_q <= in_layout_i;
				last_cmix_q   <= cmix_code;
				last_smix_q   <= smix_code;
				frame_cnt_q   <= frame_cnt_q + `TCDMX_CNT_ONE;
			end else if (out_ready_i) begin
				out_valid_q <= 1'b0;
			end
		end
	end

	assign out_valid_o = out_valid_q;
	assign out_left_o  = out_left_q;
	assign out_right_o = out_right_q;
	assign out_mono_o  = out_mono_q;

	// ****************************************************************
	// AXI4-Lite write channel
	// ****************************************************************
	wire aw_fire;
	wire w_fire;
	wire wr_go;
	wire wr_hit;

	// address and data may arrive in either order and are held apart
	assign s_axi_awready = !aw_held_q && !bvalid_q;
	assign s_axi_wready  = !w_held_q && !bvalid_q;
	assign aw_fire       = s_axi_awvalid && s_axi_awready;
	assign w_fire        = s_axi_wvalid && s_axi_wready;
	assign wr_go         = aw_held_q && w_held_q && !bvalid_q;
	assign wr_hit        = (aw_addr_q == `TCDMX_ADDR_CTRL);

	always @(posedge clock_i) begin
		if (!resetn_i) begin
			aw_held_q <= 1'b0;
			aw_addr_q <= {`TCDMX_ADDR_W{1'b0}};
			w_held_q  <= 1'b0;
			w_data_q  <= {`TCDMX_DATA_W{1'b0}};
			w_strb_q  <= 4'h0;
			bvalid_q  <= 1'b0;
			bresp_q   <= `TCDMX_RESP_OKAY;
			ctrl_q    <= `TCDMX_CTRL_RESET;
		end else begin
			if (aw_fire) begin
				aw_held_q <= 1'b1;
				aw_addr_q <= {s_axi_awaddr[`TCDMX_ADDR_W-1:2], 2'h0};
			end
			if (w_fire) begin
				w_held_q <= 1'b1;
				w_data_q <= s_axi_wdata;
				w_strb_q <= s_axi_wstrb;
			end
			if (wr_go) begin
				aw_held_q <= 1'b0;
				w_held_q  <= 1'b0;
				bvalid_q  <= 1'b1;
				bresp_q   <= wr_hit ? `TCDMX_RESP_OKAY : `TCDMX_RESP_SLVERR;
				// mode changes take effect on the next accepted frame
				if (wr_hit && w_strb_q[0]) begin
					ctrl_q <= w_data_q[`TCDMX_CTRL_W-1:0];
				end
			end else if (bvalid_q && s_axi_bready) begin
				bvalid_q <= 1'b0;
			end
		end
	end

	assign s_axi_bvalid = bvalid_q;
	assign s_axi_bresp  = bresp_q;

	// ****************************************************************
	// AXI4-Lite read channel
	// ****************************************************************
	reg  [`TCDMX_DATA_W-1:0] rd_word;
	reg  [1:0]               rd_resp;
	wire [`TCDMX_ADDR_W-1:0] rd_addr;

	assign rd_addr       = {s_axi_araddr[`TCDMX_ADDR_W-1:2], 2'h0};
	assign s_axi_arready = !rvalid_q;

	always @* begin
		rd_word = {`TCDMX_DATA_W{1'b0}};
		rd_resp = `TCDMX_RESP_OKAY;
		case (rd_addr)
			`TCDMX_ADDR_CTRL: begin
				rd_word[`TCDMX_CTRL_W-1:0] = ctrl_q;
			end
			`TCDMX_ADDR_STATUS: begin
				rd_word[`TCDMX_STAT_LAYOUT_LO +: `TCDMX_LAYOUT_W] = last_layout_q;
				rd_word[`TCDMX_STAT_CMIX_LO +: `TCDMX_LVL_W]      = last_cmix_q;
				rd_word[`TCDMX_STAT_SMIX_LO +: `TCDMX_LVL_W]      = last_smix_q;
				rd_word[`TCDMX_STAT_MONO]                         = out_mono_q;
				rd_word[`TCDMX_STAT_MATRIX]                       = matrix_sel;
				rd_word[`TCDMX_STAT_BUSY]                         = out_valid_q;
			end
			`TCDMX_ADDR_COUNT: begin
				rd_word = frame_cnt_q;
			end
			default: begin
				rd_resp = `TCDMX_RESP_SLVERR;
			end
		endcase
	end

	always @(posedge clock_i) begin
		if (!resetn_i) begin
			rvalid_q <= 1'b0;
			rdata_q  <= {`TCDMX_DATA_W{1'b0}};
			rresp_q  <= `TCDMX_RESP_OKAY;
		end else begin
			if (s_axi_arvalid && s_axi_arready) begin
				rvalid_q <= 1'b1;
				rdata_q  <= rd_word;
				rresp_q  <= rd_resp;
			end else if (rvalid_q && s_axi_rready) begin
				rvalid_q <= 1'b0;
			end
		end
	end

	assign s_axi_rvalid = rvalid_q;
	assign s_axi_rdata  = rdata_q;
	assign s_axi_rresp  = rresp_q;

endmodule // tcdmx_downmixer

`default_nettype wire

// >>> dv/tcdmx_ports_asserts.sv
/*
 * Port checker of the two-channel downmixer: stream handshake, 2/0 gains,
 * mono equality and bus answers.
 * Assumes one clock, synchronous active-low reset, bound to the top module.
 */
`timescale 1ns/10ps
`default_nettype none
module tcdmx_ports_asserts (
	input wire logic        clock_i,
	input wire logic        resetn_i,
	input wire logic        in_valid_i,
	input wire logic        in_ready_o,
	input wire logic [2:0]  in_layout_i,
	input wire logic [15:0] in_left_i,
	input wire logic [15:0] in_right_i,
	input wire logic        out_valid_o,
	input wire logic        out_ready_i,
	input wire logic [15:0] out_left_o,
	input wire logic [15:0] out_right_o,
	input wire logic        out_mono_o,
	input wire logic        s_axi_arvalid,
	input wire logic        s_axi_arready,
	input wire logic        s_axi_rvalid,
	input wire logic        s_axi_rready,
	input wire logic        s_axi_bvalid,
	input wire logic        s_axi_bready
);
	default clocking @(posedge clock_i); endclocking
	default disable iff (!resetn_i);
	// 2/0 frames carry only front terms, so the scaled result is known
	function automatic logic [15:0] mixf(input logic [15:0] a, b, input int k, sh);
		int p;
		p = (k * $signed(a) + k * $signed(b)) >>> sh;
		return p[15:0];
	endfunction
	property p_answer;
		in_valid_i && in_ready_o |=> out_valid_o;
	endproperty
	a_answer: assert property (p_answer) else $error("result missing");
	property p_refused;
		out_valid_o && !out_ready_i |-> !in_ready_o;
	endproperty
	a_refused: assert property (p_refused) else $error("frame taken while full");
	property p_hold;
		out_valid_o && !out_ready_i |=> out_valid_o && $stable(out_left_o)
			&& $stable(out_right_o) && $stable(out_mono_o);
	endproperty
	a_hold: assert property (p_hold) else $error("result changed while stalled");
	property p_drain;
		out_valid_o && out_ready_i && !(in_valid_i && in_ready_o) |=> !out_valid_o;
	endproperty
	a_drain: assert property (p_drain) else $error("result not released");
	property p_mono_eq;
		out_valid_o && out_mono_o |-> out_left_o == out_right_o;
	endproperty
	a_mono_eq: assert property (p_mono_eq) else $error("mono sides differ");
	property p_front;
		in_valid_i && in_ready_o && in_layout_i == 3'h2 |=> out_mono_o
			|| out_left_o == mixf($past(in_left_i), 16'h0000, 26, 6)
			|| out_left_o == mixf($past(in_left_i), 16'h0000, 20, 6);
	endproperty
	a_front: assert property (p_front) else $error("front gain wrong");
	property p_mono_front;
		in_valid_i && in_ready_o && in_layout_i == 3'h2 |=> !out_mono_o
			|| out_left_o == mixf($past(in_left_i), $past(in_right_i), 26, 7);
	endproperty
	a_mono_front: assert property (p_mono_front) else $error("mono gain wrong");
	property p_read;
		s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
	endproperty
	a_read: assert property (p_read) else $error("read not answered");
	property p_ronce;
		s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid;
	endproperty
	a_ronce: assert property (p_ronce) else $error("read answered twice");
	property p_bonce;
		s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid;
	endproperty
	a_bonce: assert property (p_bonce) else $error("write answered twice");
endmodule // tcdmx_ports_asserts
bind tcdmx_downmixer tcdmx_ports_asserts u_chk (.clock_i, .resetn_i, .in_valid_i,
	.in_ready_o, .in_layout_i, .in_left_i, .in_right_i, .out_valid_o, .out_ready_i,
	.out_left_o, .out_right_o, .out_mono_o, .s_axi_arvalid, .s_axi_arready,
	.s_axi_rvalid, .s_axi_rready, .s_axi_bvalid, .s_axi_bready);
`default_nettype wire

// >>> dv/tcdmx_sink_model.sv
/*
 * Output stage model: accepts results promptly or with random stalls.
 * Assumes the downmixer's clock and synchronous active-low reset.
 */
`timescale 1ns/10ps
`default_nettype none
module tcdmx_sink_model (
	input  wire logic clock_i,
	input  wire logic resetn_i,
	input  wire logic slow_i,
	output var  logic ready_o
);
	integer seed = 67651;
	// ready may drop with a result waiting, as a busy stage would
	always @(posedge clock_i) begin
		if (!resetn_i)
			ready_o <= 1'b0;
		else
			ready_o <= slow_i ? (($random(seed) & 3) == 0) : 1'b1;
	end
endmodule // tcdmx_sink_model
`default_nettype wire

// >>> dv/testbench.sv
/*
 * Self-checking bench of the two-channel downmixer: register bus, every
 * control mode, random and full-scale frames against a reference mix.
 * Assumes the design's header is on the include path.
 */
`timescale 1ns/10ps
`default_nettype none
module testbench;
	logic clock_i, resetn_i, slow, in_valid_i, out_ready_i;
	logic [2:0] in_layout_i;
	logic [1:0] in_cmix_i, in_smix_i, rs;
	logic [15:0] in_left_i, in_centre_i, in_right_i, in_lsur_i, in_rsur_i;
	wire logic in_ready_o, out_valid_o, out_mono_o;
	wire logic [15:0] out_left_o, out_right_o;
	logic [3:0] s_axi_awaddr, s_axi_araddr, s_axi_wstrb;
	logic [31:0] s_axi_wdata, d, r1, r2, r3;
	logic s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
	wire logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	wire logic [1:0] s_axi_bresp, s_axi_rresp;
	wire logic [31:0] s_axi_rdata;
	logic [7:0] ctrl;
	logic [32:0] exq[$];
	logic [32:0] ex;
	integer seed = 67651;
	int n_fail = 0, n_tests = 0, cycles = 0;
	tcdmx_downmixer dut (.clock_i, .resetn_i, .in_valid_i, .in_ready_o, .in_layout_i,
		.in_cmix_i, .in_smix_i, .in_left_i, .in_centre_i, .in_right_i, .in_lsur_i,
		.in_rsur_i, .out_valid_o, .out_ready_i, .out_left_o, .out_right_o, .out_mono_o,
		.s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
		.s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
		.s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
		.s_axi_rvalid, .s_axi_rready);
	tcdmx_sink_model u_sink (.clock_i, .resetn_i, .slow_i(slow), .ready_o(out_ready_i));
	// ****************************************************************
	// reference mix and checks
	// ****************************************************************
	function automatic logic [32:0] mix(input logic [2:0] ly, input logic [1:0] cm, sm,
		input logic mtx, mo, input logic [15:0] l, c, r, ls, rs);
		int hc, n1, n2, kc, ks, sl, sr, al, ar, m;
		hc = ly inside {3'h3, 3'h5, 3'h7};
		n1 = ly inside {3'h4, 3'h5};
		n2 = ly inside {3'h6, 3'h7};
		sl = $signed(ls);
		sr = n1 ? sl : $signed(rs);
		kc = hc ? (cm == 2'h0 ? 18 : cm == 2'h2 ? 13 : 15) : 0;
		ks = n2 ? (sm == 2'h0 ? 18 : sm == 2'h2 ? 0 : 13) : n1 ? (sm == 2'h0 ? 13 : sm == 2'h2 ? 0 : 9) : 0;
		al = 26 * $signed(l) + kc * $signed(c) + ks * sl;
		ar = 26 * $signed(r) + kc * $signed(c) + ks * sr;
		m = (al + ar) >>> 7;
		if (mo)
			return {1'b1, m[15:0], m[15:0]};
		if (mtx) begin
			sr = n2 ? sl + $signed(rs) : n1 ? sl : 0;
			al = 20 * $signed(l) + (hc ? 14 : 0) * $signed(c) - 14 * sr;
			ar = 20 * $signed(r) + (hc ? 14 : 0) * $signed(c) + 14 * sr;
		end
		al = al >>> 6;
		ar = ar >>> 6;
		return {1'b0, al[15:0], ar[15:0]};
	endfunction
	task automatic check(input logic [32:0] seen, exp);
		n_tests++;
		if (seen !== exp) begin
			n_fail++;
			$display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic print_verdict;
		$display("checks %0d mismatches %0d", n_tests, n_fail);
		if (n_fail == 0 && n_tests > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	// ****************************************************************
	// bus and stream drivers
	// ****************************************************************
	task automatic axi_wr(input logic [3:0] a, input logic [31:0] v);
		logic aw, w, b;
		b = 0;
		@(posedge clock_i);
		s_axi_awaddr <= a; s_axi_awvalid <= 1; s_axi_wdata <= v;
		s_axi_wvalid <= 1; s_axi_bready <= 1;
		while (!b) begin
			@(negedge clock_i);
			aw = s_axi_awvalid && s_axi_awready;
			w = s_axi_wvalid && s_axi_wready;
			b = s_axi_bvalid;
			rs = s_axi_bresp;
			@(posedge clock_i);
			if (aw) s_axi_awvalid <= 0;
			if (w) s_axi_wvalid <= 0;
			if (b) s_axi_bready <= 0;
		end
	endtask
	task automatic axi_rd(input logic [3:0] a);
		logic ar, r;
		r = 0;
		@(posedge clock_i);
		s_axi_araddr <= a; s_axi_arvalid <= 1; s_axi_rready <= 1;
		while (!r) begin
			@(negedge clock_i);
			ar = s_axi_arvalid && s_axi_arready;
			r = s_axi_rvalid;
			d = s_axi_rdata;
			rs = s_axi_rresp;
			@(posedge clock_i);
			if (ar) s_axi_arvalid <= 0;
			if (r) s_axi_rready <= 0;
		end
	endtask
	// keeps valid up so consecutive calls give back-to-back frames
	task automatic send(input logic [15:0] l, c, r, ls, rsr, input logic [2:0] ly,
		input logic [1:0] cm, sm);
		logic go;
		go = 0;
		in_left_i <= l; in_centre_i <= c; in_right_i <= r; in_lsur_i <= ls;
		in_rsur_i <= rsr; in_layout_i <= ly; in_cmix_i <= cm; in_smix_i <= sm;
		in_valid_i <= 1;
		while (!go) begin
			@(negedge clock_i);
			go = in_ready_o;
			@(posedge clock_i);
		end
		exq.push_back(mix(ly, ctrl[2] ? ctrl[5:4] : cm, ctrl[2] ? ctrl[7:6] : sm,
			ctrl[0], ctrl[1], l, c, r, ls, rsr));
	endtask
	always @(negedge clock_i) begin
		if (resetn_i && out_valid_o && out_ready_i) begin
			ex = exq.size() ? exq.pop_front() : ~{out_mono_o, out_left_o, out_right_o};
			check({out_mono_o, out_left_o, out_right_o}, ex);
		end
	end
	always @(posedge clock_i) begin
		cycles <= cycles + 1;
		if (cycles == 30000) begin
			n_fail++;
			print_verdict;
		end
	end
	initial begin
		clock_i = 0;
		forever #2 clock_i = ~clock_i;
	end
	// ****************************************************************
	// main sequence
	// ****************************************************************
	initial begin
		{resetn_i, slow, in_valid_i, in_layout_i, in_cmix_i, in_smix_i} = '0;
		{in_left_i, in_centre_i, in_right_i, in_lsur_i, in_rsur_i} = '0;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata, ctrl} = '0;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
		s_axi_wstrb = 4'hf;
		repeat (5) @(posedge clock_i);
		resetn_i <= 1;
		axi_rd(4'h0);
		check({1'b0, d}, 33'h0);
		axi_rd(4'hc);
		check({29'h0, rs, d[1:0]}, {29'h0, 2'h2, 2'h0});
		axi_wr(4'h4, 32'h000000ff);
		check({31'h0, rs}, 33'h2);
		for (int cfg = 0; cfg < 8; cfg++) begin
			r1 = $random(seed);
			ctrl = {r1[3:0], 1'b0, cfg[2:0]};
			axi_wr(4'h0, {24'h0, ctrl});
			slow <= cfg[0] ^ cfg[2];
			check({31'h0, rs}, 33'h0);
			axi_rd(4'h0);
			check({1'b0, d}, {25'h0, ctrl});
			@(posedge clock_i);
			for (int i = 0; i < 11; i++) begin
				r1 = $random(seed);
				r2 = $random(seed);
				r3 = $random(seed);
				send(r1[15:0], r1[31:16], r2[15:0], r2[31:16], r3[15:0], r3[18:16],
					r3[20:19], r3[22:21]);
			end
			// full-scale, negative surrounds against positive fronts, reserved level codes
			send(16'h7fff, 16'h7fff, 16'h7fff, 16'h8000, 16'h8000, 3'h7, 2'h3, 2'h3);
			in_valid_i <= 0;
			while (exq.size() != 0) @(posedge clock_i);
			axi_rd(4'h4);
			check({27'h0, d[10:8], d[2:0]}, {28'h0, ctrl[0], ctrl[1], 3'h7});
			check({25'h0, d[7:0]}, {25'h0, ctrl[2] ? ctrl[7:4] : 4'hf, 1'b0, 3'h7});
		end
		axi_rd(4'h8);
		check({1'b0, d}, 33'd96);
		print_verdict;
	end
endmodule // testbench
`default_nettype wire
